// File: pmrs_pkg.sv
// Constants, states and carriers for the power-mode and reset sequencer
// What this block does
// R01 - Startup counter counts eight 5MHz cycles at power-up and every interrupt wake from stop.
// R02 - Supply counts as stable only after three to four 32kHz cycles.
// R03 - Analog front end leaves reset at least one 32kHz cycle before the processor.
// R04 - Startup counter runs only during a startup count, otherwise fully off.
// R05 - Idle bit write freezes instruction pointer, stops fetch, keeps clocks and peripherals.
// R06 - Enabled interrupt ends idle, clears idle bit, resumes at next instruction.
// R07 - Any reset ends idle, resets processor and clears idle bit.
// R08 - Stop bit write halts system clocks, timers, serial; analog front end may stay.
// R09 - Stop keeps clock control; reset pin or power loss exit restores defaults.
// R10 - Stop exits on external, timer, watchdog, analog front end interrupts or reset pin.
// R11 - Stop exit: ungate clock, clear counter, wait 10us, count eight cycles, resume.
// R12 - In stop only timer, watchdog and analog front end may run, when enabled.
// R13 - Four reset sources; watchdog and external reset keep 5MHz clock, block execution.
// R14 - Hold reset below supply threshold, start oscillator, count eight, start at 8000h.
// R15 - Power-on reset sets its flag; software clears it after reading.
// R16 - Watchdog expiry holds reset about 90 system cycles, then runs at 8000h.
// R17 - Watchdog reset sets its flag; only software clears it.
// R18 - Outside party holds reset pin low four clock cycles with clock running.
// R19 - Reset lasts while pin is low; leaves reset within four cycles at 8000h.
// R20 - Reset in stop ends stop, restarts at 8000h after four cycle delay.
// R21 - Reset pin is two-way; watchdog or internal reset drives it low.
// R22 - ROM operation done with programming enable set causes internal system reset.
// R23 - Oscillator stops only in stop with power-down setting 6, or in power-on reset while supply is low.
// R24 - Wake sources need no system clock and are synchronised before restart.
package pmrs_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 100;
  localparam int SYS_HZ = 5_000_000;
  localparam int SLOW_HZ = 32_768;
  localparam int SYS_DIV = CLK_HZ / SYS_HZ;
  localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam int FLASH_NS = 10_000;
  localparam logic [7:0] FLASH_CYC = 8'((FLASH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] XDOG_TICKS = 8'h08;
  localparam logic [7:0] SUPPLY_TICKS = 8'h04;
  localparam logic [7:0] AFE_LEAD_TICKS = 8'h02;
  localparam logic [7:0] WDT_RST_TICKS = 8'h5A;
  localparam logic [7:0] INT_RST_TICKS = 8'h04;
  localparam logic [7:0] EXIT_TICKS = 8'h04;
  localparam logic [2:0] EXT_MIN_TICKS = 3'h4;
  localparam logic [2:0] PD_OSC_OFF = 3'h6;
  localparam logic [15:0] RESTART_VEC = 16'h8000;
  localparam int WAKE_W = 4;

  typedef enum logic [3:0] {
    ST_POR, ST_AFE, ST_FLASH, ST_XDOG, ST_RUN, ST_IDLE,
    ST_STOP, ST_WDT, ST_INT, ST_EXT, ST_EXIT
  } pmrs_state_e;

  typedef struct packed {
    logic ext_irq;
    logic tmr_irq;
    logic wdt_irq;
    logic afe_irq;
  } pmrs_wake_s;
endpackage : pmrs_pkg

// File: pmrs_tick_div.sv
// Divider that turns the core clock into a one-cycle enable pulse
`timescale 1ns/100ps
module pmrs_tick_div import pmrs_pkg::*; #(
  parameter int DIV = 2
) (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;

  always_comb begin
    cnt_nxt = (cnt_r == 9'(DIV - 1)) ? 9'h000 : cnt_r + 9'h001;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= 9'h000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick = (cnt_r == 9'(DIV - 1));
endmodule : pmrs_tick_div

// File: pmrs_sync2.sv
// Two-stage synchroniser for the wake request levels
`timescale 1ns/100ps
module pmrs_sync2 import pmrs_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WAKE_W-1:0] d,
  output logic [WAKE_W-1:0] q
);
  logic [WAKE_W-1:0] meta_r;
  logic [WAKE_W-1:0] sync_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule : pmrs_sync2

// File: pmrs_top.sv
// Power-mode and reset sequencer: startup, idle, stop, reset sources and flags
`timescale 1ns/100ps
module pmrs_top import pmrs_pkg::*; (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic SUPPLY_OK,
  input wire logic RST_PIN_I,
  output logic RST_PIN_O,
  output logic RST_PIN_OE,
  input wire logic IDLE_SET,
  input wire logic STOP_SET,
  input wire logic IRQ_PENDING,
  input wire pmrs_wake_s WAKE,
  input wire logic TIMER_RUN_ENABLE,
  input wire logic WATCHDOG_IRQ_ENABLE,
  input wire logic WDT_EXPIRE,
  input wire logic ROM_OPERATION_DONE,
  input wire logic SYSTEM_PROGRAMMING_ENABLE,
  input wire logic [2:0] POWER_DOWN_SETTING,
  input wire logic PWR_ON_FLAG_CLR,
  input wire logic WATCHDOG_RESET_FLAG_CLR,
  output logic CPU_RUN,
  output logic CPU_RESET,
  output logic INSTRUCTION_POINTER_HOLD,
  output logic ANALOG_FRONT_END_RESET,
  output logic IDLE_BIT,
  output logic STOP_BIT,
  output logic SYS_CLK_EN,
  output logic OSC_EN,
  output logic FLASH_PWR_EN,
  output logic XDOG_ACTIVE,
  output logic TMR_CLK_EN,
  output logic WDT_CLK_EN,
  output logic CLK_CTRL_DEFAULT,
  output logic [15:0] RESTART_ADDR,
  output logic PWR_ON_FLAG,
  output logic WATCHDOG_RESET_FLAG
);
  pmrs_state_e state_r;
  pmrs_state_e state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [2:0] low_r;
  logic [2:0] low_nxt;
  logic boot_r;
  logic boot_nxt;
  logic por_r;
  logic por_nxt;
  logic watchdog_reset_flag_r;
  logic watchdog_reset_flag_nxt;
  logic sys_tick;
  logic slow_tick;
  logic [WAKE_W-1:0] wake_raw;
  logic [WAKE_W-1:0] wake_sync;
  logic wake_any;
  logic ext_req;
  logic active;
  logic adv;

  pmrs_tick_div #(.DIV(SYS_DIV)) u_sys_div (
    .clk(CLK),
    .resetn(RESETN),
    .tick(sys_tick)
  );

  pmrs_tick_div #(.DIV(SLOW_DIV)) u_slow_div (
    .clk(CLK),
    .resetn(RESETN),
    .tick(slow_tick)
  );

  // Gating needs no system clock; the levels are synchronised before use [R24] [R10] [R12]
  assign wake_raw = {WAKE.ext_irq, WAKE.tmr_irq & TIMER_RUN_ENABLE,
                     WAKE.wdt_irq & WATCHDOG_IRQ_ENABLE, WAKE.afe_irq};

  pmrs_sync2 u_wake_sync (
    .clk(CLK),
    .resetn(RESETN),
    .d(wake_raw),
    .q(wake_sync)
  );

  assign wake_any = |wake_sync;
  assign active = (state_r == ST_RUN) || (state_r == ST_IDLE);
  assign ext_req = (low_r == EXT_MIN_TICKS) && !RST_PIN_I;

  always_comb begin
    state_nxt = state_r;
    low_nxt = low_r;
    boot_nxt = boot_r;
    // Pin low filter, blind while the block drives the pin itself [R18]
    if (RST_PIN_I || RST_PIN_OE) begin
      low_nxt = 3'h0;
    end else if (sys_tick && low_r != EXT_MIN_TICKS) begin
      low_nxt = low_r + 3'h1;
    end
    unique case (state_r)
      ST_POR: begin
        if (SUPPLY_OK && slow_tick && cnt_r == SUPPLY_TICKS - 8'h01) begin
          state_nxt = ST_AFE; // [R02]
        end
      end
      ST_AFE: begin
        if (slow_tick && cnt_r == AFE_LEAD_TICKS - 8'h01) begin
          state_nxt = ST_XDOG; // [R03]
        end
      end
      ST_FLASH: begin
        if (cnt_r == FLASH_CYC - 8'h01) begin
          state_nxt = ST_XDOG; // [R11]
        end
      end
      ST_XDOG: begin
        if (sys_tick && cnt_r == XDOG_TICKS - 8'h01) begin
          state_nxt = ST_RUN; // [R01] [R14]
        end
      end
      ST_RUN: begin
        if (STOP_SET) begin
          state_nxt = ST_STOP; // [R08]
        end else if (IDLE_SET) begin
          state_nxt = ST_IDLE; // [R05]
        end
      end
      ST_IDLE: begin
        if (IRQ_PENDING) begin
          state_nxt = ST_RUN; // [R06]
        end
      end
      ST_STOP: begin
        if (wake_any) begin
          state_nxt = ST_FLASH; // [R10] [R11]
        end
      end
      ST_WDT: begin
        if (sys_tick && cnt_r == WDT_RST_TICKS - 8'h01) begin
          state_nxt = ST_RUN; // [R16]
        end
      end
      ST_INT: begin
        if (sys_tick && cnt_r == INT_RST_TICKS - 8'h01) begin
          state_nxt = ST_RUN;
        end
      end
      ST_EXT: begin
        if (RST_PIN_I) begin
          state_nxt = ST_EXIT; // [R19]
        end
      end
      ST_EXIT: begin
        if (sys_tick && cnt_r == EXIT_TICKS - 8'h01) begin
          state_nxt = ST_RUN; // [R19] [R20]
        end
      end
    endcase
    // Pin reset overrides every mode but ST_POR and ST_AFE; watchdog and internal reset act in run and idle only [R07] [R13]
    if (ext_req && state_r != ST_POR && state_r != ST_AFE) begin
      state_nxt = ST_EXT; // [R20]
    end else if (active && WDT_EXPIRE) begin
      state_nxt = ST_WDT; // [R16]
    end else if (active && ROM_OPERATION_DONE && SYSTEM_PROGRAMMING_ENABLE) begin
      state_nxt = ST_INT; // [R22]
    end
    if (!SUPPLY_OK) begin
      state_nxt = ST_POR; // [R14]
    end
    if (state_r == ST_POR) begin
      boot_nxt = 1'b1;
    end else if (state_r == ST_RUN) begin
      boot_nxt = 1'b0;
    end
  end

  // Shared count only advances in timed states, so it idles at zero [R04]
  always_comb begin
    adv = 1'b0;
    unique case (state_r)
      ST_POR, ST_AFE: adv = slow_tick && SUPPLY_OK;
      ST_FLASH: adv = 1'b1;
      ST_XDOG, ST_WDT, ST_INT, ST_EXIT: adv = sys_tick;
      default: adv = 1'b0;
    endcase
    // A supply dip in the power-on wait restarts the stability count [R02]
    if (state_nxt != state_r || !SUPPLY_OK) begin
      cnt_nxt = 8'h00; // [R11]
    end else if (adv) begin
      cnt_nxt = cnt_r + 8'h01;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // Set wins over a same-cycle software clear
  always_comb begin
    por_nxt = por_r;
    if (PWR_ON_FLAG_CLR) begin
      por_nxt = 1'b0;
    end
    if (!SUPPLY_OK) begin
      por_nxt = 1'b1; // [R15]
    end
    watchdog_reset_flag_nxt = watchdog_reset_flag_r;
    if (WATCHDOG_RESET_FLAG_CLR) begin
      watchdog_reset_flag_nxt = 1'b0;
    end
    if (state_nxt == ST_WDT && state_r != ST_WDT) begin
      watchdog_reset_flag_nxt = 1'b1; // [R17]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_r <= ST_POR;
      cnt_r <= 8'h00;
      low_r <= 3'h0;
      boot_r <= 1'b1;
      por_r <= 1'b1; // [R15]
      watchdog_reset_flag_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      low_r <= low_nxt;
      boot_r <= boot_nxt;
      por_r <= por_nxt;
      watchdog_reset_flag_r <= watchdog_reset_flag_nxt;
    end
  end

  assign CPU_RUN = (state_r == ST_RUN);
  assign INSTRUCTION_POINTER_HOLD = !CPU_RUN; // [R05]
  assign CPU_RESET = (state_r == ST_POR) || (state_r == ST_AFE) || (state_r == ST_WDT)
                     || (state_r == ST_INT) || (state_r == ST_EXT) || (state_r == ST_EXIT)
                     || (state_r == ST_XDOG && boot_r); // [R13]
  assign ANALOG_FRONT_END_RESET = (state_r == ST_POR); // [R03]
  assign IDLE_BIT = (state_r == ST_IDLE); // [R06] [R07]
  assign STOP_BIT = (state_r == ST_STOP);
  assign SYS_CLK_EN = (state_r != ST_STOP) && (state_r != ST_POR); // [R08] [R13]
  assign OSC_EN = !(state_r == ST_STOP && POWER_DOWN_SETTING == PD_OSC_OFF)
                  && !(state_r == ST_POR && !SUPPLY_OK); // [R23] [R14]
  assign FLASH_PWR_EN = (state_r != ST_STOP);
  assign XDOG_ACTIVE = (state_r == ST_XDOG); // [R04]
  assign TMR_CLK_EN = (state_r == ST_STOP) ? TIMER_RUN_ENABLE : 1'b1; // [R12]
  assign WDT_CLK_EN = (state_r == ST_STOP) ? WATCHDOG_IRQ_ENABLE : 1'b1; // [R12]
  assign CLK_CTRL_DEFAULT = (state_r == ST_POR) || (state_r == ST_EXT); // [R09]
  assign RST_PIN_OE = (state_r == ST_WDT) || (state_r == ST_INT); // [R21]
  assign RST_PIN_O = 1'b0;
  assign RESTART_ADDR = RESTART_VEC; // [R14] [R16] [R19]
  assign PWR_ON_FLAG = por_r;
  assign WATCHDOG_RESET_FLAG = watchdog_reset_flag_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  property p_xdog_len;
    (state_r == ST_XDOG && state_nxt == ST_RUN) |-> (cnt_r == XDOG_TICKS - 8'h01) && sys_tick;
  endproperty
  a_xdog_len: assert property (p_xdog_len) else $error("startup count too short"); // [R01]

  property p_supply_wait;
    (state_r == ST_POR && state_nxt == ST_AFE) |-> (cnt_r == SUPPLY_TICKS - 8'h01) && SUPPLY_OK;
  endproperty
  a_supply_wait: assert property (p_supply_wait) else $error("supply wait wrong"); // [R02]

  property p_afe_lead;
    $fell(ANALOG_FRONT_END_RESET) && SUPPLY_OK |-> CPU_RESET [*8];
  endproperty
  a_afe_lead: assert property (p_afe_lead) else $error("cpu released with front end"); // [R03]

  property p_idle_enter;
    (state_r == ST_RUN && IDLE_SET && !STOP_SET && !ext_req && !WDT_EXPIRE && !ROM_OPERATION_DONE
     && SUPPLY_OK) |=> IDLE_BIT && !CPU_RUN && SYS_CLK_EN;
  endproperty
  a_idle_enter: assert property (p_idle_enter) else $error("idle entry wrong"); // [R05]

  property p_idle_exit;
    (IDLE_BIT && IRQ_PENDING && !ext_req && !WDT_EXPIRE && !ROM_OPERATION_DONE && SUPPLY_OK)
    |=> !IDLE_BIT && CPU_RUN;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle exit wrong"); // [R06]

  property p_osc_off;
    (STOP_BIT && POWER_DOWN_SETTING != PD_OSC_OFF) |-> OSC_EN && !SYS_CLK_EN;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator off wrongly"); // [R23]

  property p_flash_wait;
    (state_r == ST_FLASH && state_nxt == ST_XDOG) |-> (cnt_r == FLASH_CYC - 8'h01);
  endproperty
  a_flash_wait: assert property (p_flash_wait) else $error("flash wait wrong"); // [R11]

  property p_wdt_hold;
    $rose(state_r == ST_WDT) |-> RST_PIN_OE [*8] ##0 WATCHDOG_RESET_FLAG;
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog reset not held"); // [R16]

  property p_watchdog_reset_flag_keep;
    (WATCHDOG_RESET_FLAG && !WATCHDOG_RESET_FLAG_CLR) |=> WATCHDOG_RESET_FLAG;
  endproperty
  a_watchdog_reset_flag_keep: assert property (p_watchdog_reset_flag_keep) else $error("watchdog flag lost"); // [R17]

  property p_ext_exit;
    $fell(state_r == ST_EXT) && state_r == ST_EXIT |-> ##[1:9] CPU_RUN;
  endproperty
  a_ext_exit: assert property (p_ext_exit) else $error("late exit from reset"); // [R19]

  property p_int_rst;
    (active && ROM_OPERATION_DONE && SYSTEM_PROGRAMMING_ENABLE && !ext_req && !WDT_EXPIRE
     && SUPPLY_OK) |=> RST_PIN_OE && !RST_PIN_O;
  endproperty
  a_int_rst: assert property (p_int_rst) else $error("internal reset missing"); // [R22]

  c_boot: cover property ($rose(CPU_RUN) && !$past(IDLE_BIT));
  c_idle: cover property (IDLE_BIT ##1 CPU_RUN);
  c_stop_wake: cover property (STOP_BIT ##1 state_r == ST_FLASH);
  c_wdt: cover property (state_r == ST_WDT ##1 state_r == ST_RUN);
endmodule : pmrs_top

// File: pmrs_rst_drv.sv
// External reset source model pulling the open-drain reset pin low
`timescale 1ns/100ps
module pmrs_rst_drv (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] len,
  output logic pull_low
);
  logic [7:0] cnt_r = 8'h00;
  // Pin low for len cycles; released pin floats up to the pull-up level
  always_ff @(posedge clk) begin
    if (start) begin
      cnt_r <= len;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign pull_low = (cnt_r != 8'h00);
endmodule : pmrs_rst_drv

// File: pmrs_tb_top.sv
// Self-checking testbench for the power-mode and reset sequencer
`timescale 1ns/100ps
module pmrs_tb_top import pmrs_pkg::*; ;
  logic clk = 1'h0, resetn = 1'h0, sup = 1'h1, idle_set = 1'h0, stop_set = 1'h0, irq = 1'h0;
  logic ten = 1'h0, wen = 1'h0, wdx = 1'h0, rom_operation_done = 1'h0, system_programming_enable = 1'h0, pcl = 1'h0, wcl = 1'h0;
  logic drv_go = 1'h0, ok;
  logic [7:0] drv_len = 8'h00;
  logic [2:0] pd = 3'h0;
  pmrs_wake_s wake = '0;
  logic pin_o, pin_oe, run, cres, afe_rst, idle_b, stop_b, sclk, osc, xdog, tclk, wclk, cdef;
  logic por_f, wdt_f, iph, fpe;
  logic [15:0] raddr;
  wire drv_low;
  wire pin_lvl = ~(drv_low | (pin_oe & ~pin_o));
  int n_fail = 0, checks_done = 0, n, xd, k, t;
  logic [31:0] seed = 32'h54D49EE1;

  pmrs_top u_pmrs_top (.CLK(clk), .RESETN(resetn), .SUPPLY_OK(sup), .RST_PIN_I(pin_lvl),
    .RST_PIN_O(pin_o), .RST_PIN_OE(pin_oe), .IDLE_SET(idle_set), .STOP_SET(stop_set),
    .IRQ_PENDING(irq), .WAKE(wake), .TIMER_RUN_ENABLE(ten), .WATCHDOG_IRQ_ENABLE(wen),
    .WDT_EXPIRE(wdx), .ROM_OPERATION_DONE(rom_operation_done), .SYSTEM_PROGRAMMING_ENABLE(system_programming_enable),
    .POWER_DOWN_SETTING(pd), .PWR_ON_FLAG_CLR(pcl), .WATCHDOG_RESET_FLAG_CLR(wcl),
    .CPU_RUN(run), .CPU_RESET(cres), .INSTRUCTION_POINTER_HOLD(iph), .ANALOG_FRONT_END_RESET(afe_rst),
    .IDLE_BIT(idle_b), .STOP_BIT(stop_b), .SYS_CLK_EN(sclk), .OSC_EN(osc), .FLASH_PWR_EN(fpe),
    .XDOG_ACTIVE(xdog), .TMR_CLK_EN(tclk), .WDT_CLK_EN(wclk), .CLK_CTRL_DEFAULT(cdef),
    .RESTART_ADDR(raddr), .PWR_ON_FLAG(por_f), .WATCHDOG_RESET_FLAG(wdt_f));

  pmrs_rst_drv u_pmrs_rst_drv (.clk(clk), .start(drv_go), .len(drv_len), .pull_low(drv_low));

  initial begin
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Whether a stop wake source is honoured under the current enables
  function automatic logic wake_ok(input int src, input logic te, input logic we);
    return src == 2 ? te : (src == 1 ? we : 1'h1);
  endfunction : wake_ok

  function automatic logic pick(input int s);
    case (s)
      0: return run;
      1: return afe_rst;
      2: return pin_oe;
      default: return drv_low;
    endcase
  endfunction : pick

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #10;
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // Waits for a watched output to reach v; counts clock cycles with the startup counter running meanwhile
  task automatic wt(input int s, input logic v, input int lim);
    n = 0;
    xd = 0;
    while (pick(s) !== v && n < lim) begin
      cyc(1);
      n++;
      xd += int'(xdog === 1'h1);
    end
    if (n >= lim) begin
      n_fail++;
      $display("Error at %0t: wait ran out", $time);
      final_report();
    end
  endtask : wt

  initial begin
    cyc(3);
    chk({cres, afe_rst, por_f}, 3'h7);
    resetn = 1'h1;
    wt(1, 1'h0, 3000);
    chk(n >= 915 && n <= 1525, 1'h1);
    chk(run, 1'h0);
    wt(0, 1'h1, 3000);
    chk(n >= 305, 1'h1);
    chk(xd >= 15 && xd <= 17, 1'h1);
    chk({raddr, xdog, osc, iph, fpe}, {16'h8000, 4'h5});
    pcl = 1'h1;
    cyc(1);
    pcl = 1'h0;
    chk(por_f, 1'h0);
    idle_set = 1'h1;
    cyc(1);
    idle_set = 1'h0;
    chk({idle_b, run, sclk, iph}, 4'hB);
    cyc(2 + seed[2:0]);
    chk(idle_b, 1'h1);
    irq = 1'h1;
    cyc(1);
    irq = 1'h0;
    chk({idle_b, run}, 2'h1);
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      ten = seed[0];
      wen = seed[1] & (k != 1);
      pd = (k == 3) ? PD_OSC_OFF : seed[4:2];
      stop_set = 1'h1;
      cyc(1);
      stop_set = 1'h0;
      chk({stop_b, sclk, cdef, tclk, wclk, fpe}, {3'h4, ten, wen, 1'h0});
      chk(osc, pd != PD_OSC_OFF);
      ok = wake_ok(k, ten, wen);
      wake = pmrs_wake_s'(4'h1 << k);
      cyc(5);
      if (!ok) begin
        chk(stop_b, 1'h1);
        ten = 1'h1;
        wen = 1'h1;
      end
      wt(0, 1'h1, 400);
      wake = '0;
      t = n + (ok ? 5 : 0);
      chk(t >= 112 && t <= 126, 1'h1);
      chk(xd >= 15 && xd <= 17, 1'h1);
      // Let the wake synchroniser drain before the next stop
      cyc(2);
    end
    wdx = 1'h1;
    cyc(1);
    wdx = 1'h0;
    chk({pin_oe, pin_lvl, cres, wdt_f, sclk}, 5'h17);
    wt(2, 1'h0, 400);
    chk(n >= 174 && n <= 184, 1'h1);
    wt(0, 1'h1, 10);
    chk({raddr, wdt_f}, {16'h8000, 1'h1});
    wcl = 1'h1;
    cyc(1);
    wcl = 1'h0;
    chk(wdt_f, 1'h0);
    for (k = 0; k < 2; k++) begin
      system_programming_enable = k[0];
      rom_operation_done = 1'h1;
      cyc(1);
      rom_operation_done = 1'h0;
      chk({pin_oe, cres, wdt_f}, {system_programming_enable, system_programming_enable, 1'h0});
      wt(0, 1'h1, 30);
    end
    for (k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      idle_set = (k == 1);
      stop_set = (k == 2);
      cyc(1);
      idle_set = 1'h0;
      stop_set = 1'h0;
      drv_len = (k == 0) ? 8'h02 : 8'h0C + {4'h0, seed[3:0]};
      drv_go = 1'h1;
      cyc(1);
      drv_go = 1'h0;
      cyc(11);
      chk({run, cres, cdef, idle_b, stop_b, sclk}, (k == 0) ? 6'h21 : 6'h19);
      wt(3, 1'h0, 40);
      wt(0, 1'h1, 12);
      chk({n <= 9, raddr}, {1'h1, 16'h8000});
    end
    sup = 1'h0;
    cyc(5);
    chk({cres, por_f, cdef, run}, 4'hE);
    sup = 1'h1;
    wt(0, 1'h1, 3000);
    chk(raddr, 16'h8000);
    final_report();
  end
endmodule : pmrs_tb_top
